// ===== design/lhg_top.sv
// Contract
// RULE1 - Low-g asserts after (delay+1) 2.5 ms ticks
// RULE2 - Low-g delay resets to 20 ms
// RULE3 - Host avoids low-power with pre-filtered source
// RULE4 - Low-g threshold field times 7.81 mg, zero 3.91
// RULE5 - Low-g threshold independent of range setting
// RULE6 - Low-g threshold resets to 375 mg
// RULE7 - Mode bit: single-axis or axis-summing
// RULE8 - Low-g hysteresis field times 125 mg
// RULE9 - High-g hysteresis step scales with range
// RULE10 - High-g delay (field+1) ticks, reset 30 ms
// RULE11 - High-g threshold step scales with range
// RULE12 - High-g zero threshold is half step
// RULE13 - Source bit picks filtered or pre-filtered samples
// RULE14 - Delay restarts on lapse; release past hysteresis
`timescale 1ns/100ps
`default_nettype none
module lhg_top
  import lhg_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Samples
  input wire lhg_axes_t filt_axes,
  input wire logic filt_valid,
  input wire lhg_axes_t prefilt_axes,
  input wire logic prefilt_valid,
  input wire logic src_sel,
  input wire logic [1:0] acc_range,
  // Interrupt conditions
  output logic lowg_flag,
  output logic highg_flag
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_s1_r;
  logic rst_n_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  // Writes to unmapped offsets are dropped, reads of them return zero
  wire logic hit_lowg_delay = (reg_addr == OFS_LOWG_DELAY);
  wire logic hit_lowg_threshold = (reg_addr == OFS_LOWG_THRESHOLD);
  wire logic hit_mode_hysteresis = (reg_addr == OFS_MODE_HYSTERESIS);
  wire logic hit_highg_delay = (reg_addr == OFS_HIGHG_DELAY);
  wire logic hit_highg_threshold = (reg_addr == OFS_HIGHG_THRESHOLD);
  wire logic wr_lowg_delay = reg_wr && hit_lowg_delay;
  wire logic wr_lowg_threshold = reg_wr && hit_lowg_threshold;
  wire logic wr_mode_hysteresis = reg_wr && hit_mode_hysteresis;
  wire logic wr_highg_delay = reg_wr && hit_highg_delay;
  wire logic wr_highg_threshold = reg_wr && hit_highg_threshold;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] lowg_delay_r;
  logic [7:0] lowg_threshold_r;
  logic [7:0] lowg_highg_mode_hysteresis_r;
  logic [7:0] highg_delay_r;
  logic [7:0] highg_threshold_r;
  logic [7:0] reg_rdata_r;
  logic [7:0] rdata_nxt;

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lowg_delay_r <= RST_LOWG_DELAY; // [RULE2]
      lowg_threshold_r <= RST_LOWG_THRESHOLD; // [RULE6]
      lowg_highg_mode_hysteresis_r <= RST_MODE_HYSTERESIS;
      highg_delay_r <= RST_HIGHG_DELAY; // [RULE10]
      highg_threshold_r <= RST_HIGHG_THRESHOLD;
    end else begin
      if (wr_lowg_delay) begin
        lowg_delay_r <= reg_wdata;
      end
      if (wr_lowg_threshold) begin
        lowg_threshold_r <= reg_wdata;
      end
      if (wr_mode_hysteresis) begin
        lowg_highg_mode_hysteresis_r <= reg_wdata & MASK_MODE_HY;
      end
      if (wr_highg_delay) begin
        highg_delay_r <= reg_wdata;
      end
      if (wr_highg_threshold) begin
        highg_threshold_r <= reg_wdata;
      end
    end
  end

  // Top bit of the two low-g registers is write-only and reads zero
  assign rdata_nxt =
    hit_lowg_delay ? (lowg_delay_r & MASK_WO_TOP) :
    hit_lowg_threshold ? (lowg_threshold_r & MASK_WO_TOP) :
    hit_mode_hysteresis ? lowg_highg_mode_hysteresis_r :
    hit_highg_delay ? highg_delay_r :
    hit_highg_threshold ? highg_threshold_r : 8'h00;

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = reg_rdata_r;

  // ****************************************
  // Sample capture
  // ****************************************
  // Host keeps normal power while the pre-filtered source is chosen
  lhg_axes_t sample_r;
  wire logic sel_valid = src_sel ? prefilt_valid : filt_valid; // [RULE13]
  wire lhg_axes_t sel_axes = src_sel ? prefilt_axes : filt_axes; // [RULE13]

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sample_r <= '0;
    end else if (sel_valid) begin
      sample_r <= sel_axes;
    end
  end

  // ****************************************
  // Delay tick
  // ****************************************
  // One pulse per delay step, shared by both detectors
  logic [19:0] tick_cnt_r;
  logic tick_r;
  wire logic tick_end = (tick_cnt_r == 20'(TICK_LEN - 1));

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tick_cnt_r <= 20'h0_0000;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_end ? 20'h0_0000 : 20'(tick_cnt_r + 20'h0_0001);
      tick_r <= tick_end;
    end
  end

  // ****************************************
  // Levels in sample LSBs
  // ****************************************
  wire logic [7:0] lowg_threshold_field = lowg_threshold_r;
  wire logic [7:0] highg_threshold_field = highg_threshold_r;
  wire logic [1:0] lowg_hysteresis_field =
    lowg_highg_mode_hysteresis_r[LOWG_HY_LSB +: 2];
  wire logic [1:0] highg_hysteresis_field =
    lowg_highg_mode_hysteresis_r[HIGHG_HY_LSB +: 2];
  wire logic lowg_sum_mode = lowg_highg_mode_hysteresis_r[LOWG_MODE_BIT];

  // Low-g levels shrink with range so they stay fixed in mg
  wire logic [18:0] low_th_base = (lowg_threshold_field == 8'h00) ? TH_ZERO_LEVEL :
    (19'(lowg_threshold_field) << TH_STEP_SHIFT); // [RULE4]
  wire logic [18:0] low_th = low_th_base >> acc_range; // [RULE5]
  wire logic [18:0] low_hy = (19'(lowg_hysteresis_field) << HY_STEP_SHIFT) >> acc_range; // [RULE8]
  wire logic [18:0] low_exit = 19'(low_th + low_hy); // [RULE14]

  // High-g levels stay in sample units so their mg step grows with range
  wire logic [18:0] high_th = (highg_threshold_field == 8'h00) ? TH_ZERO_LEVEL : // [RULE12]
    (19'(highg_threshold_field) << TH_STEP_SHIFT); // [RULE11]
  wire logic [18:0] high_hy = 19'(highg_hysteresis_field) << HY_STEP_SHIFT; // [RULE9]
  wire logic [18:0] high_exit = (high_th > high_hy) ? 19'(high_th - high_hy) : 19'h0_0000;

  // ****************************************
  // Conditions
  // ****************************************
  wire logic [18:0] ax = lhg_abs(sample_r.x);
  wire logic [18:0] ay = lhg_abs(sample_r.y);
  wire logic [18:0] az = lhg_abs(sample_r.z);
  wire logic [18:0] asum = 19'(ax + ay + az);

  wire logic low_enter = lowg_sum_mode ? (asum < low_th) : // [RULE7]
    ((ax < low_th) && (ay < low_th) && (az < low_th));
  wire logic low_leave = lowg_sum_mode ? (asum > low_exit) : // [RULE14]
    ((ax > low_exit) || (ay > low_exit) || (az > low_exit));
  wire logic high_enter = (ax > high_th) || (ay > high_th) || (az > high_th);
  wire logic high_leave = (ax < high_exit) && (ay < high_exit) && (az < high_exit); // [RULE14]

  // ****************************************
  // Detectors
  // ****************************************
  // Each detector counts whole delay steps while its condition holds
  lhg_detect u_lowg (
    .ref_clk(ref_clk),
    .rst_n(rst_n_r),
    .tick(tick_r),
    .enter(low_enter),
    .leave(low_leave),
    .delay(lowg_delay_r),
    .flag(lowg_flag)
  ); // [RULE1]

  lhg_detect u_highg (
    .ref_clk(ref_clk),
    .rst_n(rst_n_r),
    .tick(tick_r),
    .enter(high_enter),
    .leave(high_leave),
    .delay(highg_delay_r),
    .flag(highg_flag)
  ); // [RULE10]

endmodule : lhg_top
`default_nettype wire

// ===== pkg/lhg_pkg.sv
package lhg_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_LOWG_DELAY = 8'h5a;
  localparam logic [7:0] OFS_LOWG_THRESHOLD = 8'h5b;
  localparam logic [7:0] OFS_MODE_HYSTERESIS = 8'h5c;
  localparam logic [7:0] OFS_HIGHG_DELAY = 8'h5d;
  localparam logic [7:0] OFS_HIGHG_THRESHOLD = 8'h5e;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_LOWG_DELAY = 8'h07;
  localparam logic [7:0] RST_LOWG_THRESHOLD = 8'h30;
  localparam logic [7:0] RST_MODE_HYSTERESIS = 8'h81;
  localparam logic [7:0] RST_HIGHG_DELAY = 8'h0b;
  localparam logic [7:0] RST_HIGHG_THRESHOLD = 8'hc0;

  // ****************************************
  // Field positions and read masks
  // ****************************************
  localparam int HIGHG_HY_LSB = 6;
  localparam int LOWG_MODE_BIT = 2;
  localparam int LOWG_HY_LSB = 0;
  localparam logic [7:0] MASK_WO_TOP = 8'h7f;
  localparam logic [7:0] MASK_MODE_HY = 8'hc7;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int DELAY_STEP_NS = 2500000;
  localparam int TICK_CYCLES = DELAY_STEP_NS / CLK_PERIOD_NS;

  // ****************************************
  // Scaling in sample LSBs (2 g range base)
  // ****************************************
  localparam int TH_STEP_SHIFT = 7;
  localparam int HY_STEP_SHIFT = 11;
  localparam logic [18:0] TH_ZERO_LEVEL = 19'h0_0040;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } lhg_axes_t;

  function automatic logic [18:0] lhg_abs(input logic signed [15:0] v);
    logic [16:0] m;
    m = v[15] ? 17'(-$signed({v[15], v})) : {1'b0, v};
    return {2'b00, m};
  endfunction : lhg_abs

endpackage : lhg_pkg

// ===== design/lhg_detect.sv
`timescale 1ns/100ps
`default_nettype none
module lhg_detect
  import lhg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Evaluation
  input wire logic tick,
  input wire logic enter,
  input wire logic leave,
  input wire logic [7:0] delay,
  // Result
  output logic flag
);

  logic flag_r;
  logic [7:0] cnt_r;
  wire logic expire = (cnt_r == delay);
  wire logic [7:0] cnt_inc = 8'(cnt_r + 8'h01);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
      cnt_r <= 8'h00;
    end else if (tick) begin
      if (flag_r) begin
        if (leave) begin
          flag_r <= 1'b0; // [RULE14]
        end
        cnt_r <= 8'h00;
      end else if (enter) begin
        flag_r <= expire; // [RULE1] [RULE10]
        cnt_r <= expire ? 8'h00 : cnt_inc;
      end else begin
        cnt_r <= 8'h00; // [RULE14]
      end
    end
  end

  assign flag = flag_r;

endmodule : lhg_detect
`default_nettype wire

// ===== dv/lhg_properties.sv
`timescale 1ns/100ps
`default_nettype none
module lhg_properties
  import lhg_pkg::*;
#(
  parameter int TICK_LEN = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Conditions
  input wire logic lowg_flag,
  input wire logic highg_flag
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h5a, 8'h5b: return 8'h7f;
      8'h5c: return 8'hc7;
      8'h5d, 8'h5e: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction : msk
  property p_wrrd;
    reg_wr ##1 !reg_wr ##1 (reg_rd && !reg_wr && reg_addr == $past(reg_addr, 2))
      |=> reg_rdata == ($past(reg_wdata, 3) & msk($past(reg_addr)));
  endproperty
  a_wrrd: assert property (p_wrrd) else $error("read back mismatch");
  property p_wo_top;
    reg_rd && (reg_addr == 8'h5a || reg_addr == 8'h5b) |=> !reg_rdata[7];
  endproperty
  a_wo_top: assert property (p_wo_top) else $error("top bit readable");
  property p_resv;
    reg_rd && reg_addr == 8'h5c |=> reg_rdata[5:3] == 3'b000;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_low_gap;
    $changed(lowg_flag) |=> $stable(lowg_flag) [*7];
  endproperty
  a_low_gap: assert property (p_low_gap) else $error("low flag off tick");
  property p_high_gap;
    $changed(highg_flag) |=> $stable(highg_flag) [*7];
  endproperty
  a_high_gap: assert property (p_high_gap) else $error("high flag off tick");
  property p_tick_align;
    $changed(lowg_flag) |=> !$changed(highg_flag) [*7];
  endproperty
  a_tick_align: assert property (p_tick_align) else $error("flags on different ticks");
  property p_wake;
    $rose(nrst) |-> (!lowg_flag && !highg_flag) [*8];
  endproperty
  a_wake: assert property (p_wake) else $error("flag too soon after reset");
  c_low: cover property ($rose(lowg_flag));
  c_low_clr: cover property ($fell(lowg_flag));
  c_high: cover property ($rose(highg_flag));
endmodule : lhg_properties
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
bind lhg_top lhg_properties #(.TICK_LEN(TICK_LEN)) i_props (.ref_clk(ref_clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .lowg_flag(lowg_flag), .highg_flag(highg_flag));
module testbench
  import lhg_pkg::*;
;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, filt_valid = 1'b0, prefilt_valid = 1'b0;
  logic src_sel = 1'b0, lowg_flag, highg_flag;
  logic [1:0] acc_range = 2'h0;
  lhg_axes_t filt_axes = '0, prefilt_axes = {3{16'h2000}};
  logic [7:0] rst_v [5] = '{8'h07, 8'h30, 8'h81, 8'h0b, 8'hc0};
  logic [7:0] rd_m [5] = '{8'h7f, 8'h7f, 8'hc7, 8'hff, 8'hff};
  int n_errors = 0, n_compared = 0, cyc = 0;
  always #2 ref_clk = ~ref_clk;
  lhg_top #(.TICK_LEN(8)) i_dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .filt_axes(filt_axes), .filt_valid(filt_valid), .prefilt_axes(prefilt_axes),
    .prefilt_valid(prefilt_valid), .src_sel(src_sel), .acc_range(acc_range),
    .lowg_flag(lowg_flag), .highg_flag(highg_flag));
  // ****
  // Stimulus
  // ****
  task summarize;
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [7:0] s, e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wt
  task wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    wt(1);
    chk("rdata", reg_rdata, e);
  endtask : rd
  task sa(input logic [15:0] x, yz);
    @(posedge ref_clk);
    filt_axes <= '{x, yz, yz};
    filt_valid <= 1'b1;
    prefilt_valid <= 1'b1;
    @(posedge ref_clk);
    filt_valid <= 1'b0;
    prefilt_valid <= 1'b0;
  endtask : sa
  task lo(input logic e);
    chk("lowg", {7'h00, lowg_flag}, {7'h00, e});
  endtask : lo
  task hi(input logic e);
    chk("highg", {7'h00, highg_flag}, {7'h00, e});
  endtask : hi
  // ****
  // Scenarios
  // ****
  task s_regs;
    for (int i = 0; i < 5; i++) begin
      rd(8'h5a + 8'(i), rst_v[i]);
    end
    for (int i = 0; i < 5; i++) begin
      wr(8'h5a + 8'(i), 8'hff);
      rd(8'h5a + 8'(i), rd_m[i]);
    end
    wr(8'h5f, 8'hff);
    rd(8'h5f, 8'h00);
  endtask : s_regs
  task s_low;
    wr(8'h5a, 8'h02);
    wr(8'h5b, 8'h10);
    wr(8'h5c, 8'h01);
    sa(16'h0064, 16'h0064);
    wt(14);
    lo(1'b0);
    wt(14);
    lo(1'b1);
    sa(16'h0bb8, 16'h0bb8);
    wt(30);
    lo(1'b1);
    sa(16'h1388, 16'h1388);
    wt(20);
    lo(1'b0);
    sa(16'h0064, 16'h0064);
    wt(10);
    sa(16'h2000, 16'h2000);
    wt(10);
    sa(16'h0064, 16'h0064);
    wt(12);
    lo(1'b0);
    sa(16'h2000, 16'h2000);
    @(posedge ref_clk);
    acc_range <= 2'h1;
    sa(16'h05dc, 16'h05dc);
    wt(30);
    lo(1'b0);
    @(posedge ref_clk);
    acc_range <= 2'h0;
    wt(30);
    lo(1'b1);
    sa(16'h2000, 16'h2000);
    wr(8'h5c, 8'h05);
    sa(16'h0320, 16'h0320);
    wt(30);
    lo(1'b0);
    sa(16'h0258, 16'h0258);
    wt(30);
    lo(1'b1);
    sa(16'h2000, 16'h2000);
    wr(8'h5c, 8'h01);
    @(posedge ref_clk);
    src_sel <= 1'b1;
    sa(16'h0064, 16'h0064);
    wt(30);
    lo(1'b0);
    @(posedge ref_clk);
    src_sel <= 1'b0;
  endtask : s_low
  task s_high;
    sa(16'h0bb8, 16'h0bb8);
    wr(8'h5d, 8'h00);
    wr(8'h5e, 8'h20);
    wr(8'h5c, 8'h41);
    @(posedge ref_clk);
    acc_range <= 2'h3;
    sa(16'h1388, 16'h0000);
    wt(20);
    hi(1'b1);
    sa(16'h0bb8, 16'h0000);
    wt(20);
    hi(1'b1);
    sa(16'h03e8, 16'h0000);
    wt(20);
    hi(1'b0);
    sa(16'h0028, 16'h0000);
    wr(8'h5e, 8'h00);
    wr(8'h5c, 8'h01);
    wt(20);
    hi(1'b0);
    sa(16'h0064, 16'h0000);
    wt(20);
    hi(1'b1);
  endtask : s_high
  task s_range;
    @(posedge ref_clk);
    acc_range <= 2'h2;
    sa(16'h2000, 16'h2000);
    wt(10);
    sa(16'h0258, 16'h0258);
    wt(30);
    lo(1'b0);
    sa(16'h01f4, 16'h01f4);
    wt(30);
    lo(1'b1);
  endtask : s_range
  task s_rst;
    @(posedge ref_clk);
    nrst <= 1'b0;
    wt(2);
    lo(1'b0);
    hi(1'b0);
    @(posedge ref_clk);
    nrst <= 1'b1;
    wt(3);
    for (int i = 0; i < 5; i++) begin
      rd(8'h5a + 8'(i), rst_v[i]);
    end
  endtask : s_rst
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    wt(3);
    sa(16'h2000, 16'h2000);
    s_regs();
    s_low();
    s_high();
    s_range();
    s_rst();
    summarize();
  end
endmodule : testbench
`default_nettype wire
